// ===== include/prot_pkg.sv
package prot_pkg;

  // Element and breaker counts
  localparam int NUM_ELEM    = 4;
  localparam int NUM_PHASE   = 3;
  localparam int NUM_BREAKER = 2;
  localparam int DELAY_W     = 16;

  // Register byte offsets
  localparam logic [7:0] MASTER_CTRL_OFS = 8'h00;
  localparam logic [7:0] ELEM_EN_OFS     = 8'h04;
  localparam logic [7:0] SUPERV_OFS      = 8'h08;
  localparam logic [7:0] STAGE_INH_OFS   = 8'h0C;
  localparam logic [7:0] SINGLE_PH_OFS   = 8'h10;
  localparam logic [7:0] BRK_MAP_OFS     = 8'h14;
  localparam logic [7:0] STATUS_OFS      = 8'h18;
  localparam logic [7:0] IRQ_STAT_OFS    = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h20;
  localparam logic [7:0] DELAY_BASE_OFS  = 8'h40;

  // Master control bit positions
  localparam int MC_PROT_ENABLE     = 0;
  localparam int MC_EXT_BLOCK_PERMIT = 1;
  localparam int MC_PERM_INHIBIT    = 2;
  localparam int MC_EXT_INHIBIT_PERMIT = 3;
  localparam logic [3:0] MASTER_CTRL_RST = 4'h0;

  // Status bit positions
  localparam int ST_GEN_ALARM  = 0;
  localparam int ST_GEN_TRIP   = 1;
  localparam int ST_PROT_BLOCK = 2;
  localparam int ST_CMD_BLOCK  = 3;

  // Interrupt event bit positions
  localparam int IRQ_W         = 3;
  localparam int EV_GEN_ALARM  = 0;
  localparam int EV_GEN_TRIP   = 1;
  localparam int EV_OPEN_ORDER = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : prot_pkg

// ===== src/protection_trip_aggregator.sv
`timescale 1ns/100ps

// Notes on behaviour
// R1: Master disabled or blocked silences all outputs; irq still follows sticky irq status and mask
// R2: Permitted external inputs A or B block protection
// R3: Permanent inhibit suppresses every breaker open order
// R4: Permitted external inhibit input suppresses all orders
// R5: Supervision-only elements: local status, no order
// R6: Element alarm follows its fault criterion
// R7: Element trip after continuous fault for delay
// R8: General alarm ORs non-supervision element alarms
// R9: General trip ORs non-supervision element trips
// R10: Element order from trip unless inhibited
// R11: Phase contributions only from single-phase, non-supervision
// R12: Phase alarm ORs element alarms of phase
// R13: Phase trip ORs element trips of phase
// R14: Each breaker ORs its assigned element orders
// R15: Disabled element gives no alarm, trip, order
// R16: Per-stage inhibit suppresses only that order
// R17: Single clock sampling, reset clears all outputs
// R18: Protection block dominates; inhibit touches orders only
module protection_trip_aggregator
#(
  parameter int N_ELEM = prot_pkg::NUM_ELEM,
  parameter int N_PH   = prot_pkg::NUM_PHASE,
  parameter int N_BRK  = prot_pkg::NUM_BREAKER,
  parameter int DLY_W  = prot_pkg::DELAY_W
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Element side
  input  wire logic [N_ELEM-1:0]     fault_detect,
  input  wire logic [N_ELEM*N_PH-1:0] fault_phase,
  input  wire logic                  ext_block_input_a,
  input  wire logic                  ext_block_input_b,
  input  wire logic                  ext_command_inhibit_input,
  // Element results
  output logic [N_ELEM-1:0]          elem_alarm,
  output logic [N_ELEM-1:0]          elem_trip,
  output logic [N_ELEM-1:0]          breaker_open_order,
  output logic                       general_alarm,
  output logic                       general_trip,
  output logic [N_PH-1:0]            phase_alarm,
  output logic [N_PH-1:0]            phase_trip,
  output logic [N_BRK-1:0]           breaker_open_request,
  output logic                       irq
);
  import prot_pkg::*;

  // Settings
  logic [3:0]               master_ctrl_reg;
  logic [N_ELEM-1:0]        elem_en_reg;
  logic [N_ELEM-1:0]        superv_reg;
  logic [N_ELEM-1:0]        stage_inh_reg;
  logic [N_ELEM-1:0]        single_ph_reg;
  logic [N_ELEM*N_BRK-1:0]  brk_map_reg;
  logic [DLY_W-1:0]         delay_reg [N_ELEM];
  logic [DLY_W-1:0]         timer_reg [N_ELEM];
  logic [IRQ_W-1:0]         irq_stat_reg;
  logic [IRQ_W-1:0]         irq_mask_reg;
  logic [IRQ_W-1:0]         event_next;

  // Bus state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic [31:0] rd_data_next;
  logic        rd_ok_next;

  // Blocking conditions
  logic prot_active;
  logic prot_block;
  logic cmd_block;
  logic [N_ELEM-1:0] live;
  logic [N_ELEM-1:0] alarm_next;
  logic [N_ELEM-1:0] trip_next;
  logic [N_ELEM-1:0] order_next;
  logic              gen_alarm_next;
  logic              gen_trip_next;
  logic [N_PH-1:0]   ph_alarm_next;
  logic [N_PH-1:0]   ph_trip_next;
  logic [N_BRK-1:0]  brk_next;

  // Index of an element delay word, or -1 if none
  function automatic int delay_index(input logic [7:0] addr);
    int idx;
    idx = -1;
    for (int k = 0; k < N_ELEM; k++)
    begin
      if (addr == 8'(DELAY_BASE_OFS + 8'(4 * k)))
      begin
        idx = k;
      end
    end
    return idx;
  endfunction : delay_index

  // Protection block: disabled, or permitted external block
  assign prot_block = (master_ctrl_reg[MC_EXT_BLOCK_PERMIT]
                       && (ext_block_input_a || ext_block_input_b)); // R2
  assign prot_active = master_ctrl_reg[MC_PROT_ENABLE] && !prot_block; // R1 R18
  // Command inhibit never reaches alarms or trips
  assign cmd_block = master_ctrl_reg[MC_PERM_INHIBIT]
                     || (master_ctrl_reg[MC_EXT_INHIBIT_PERMIT]
                         && ext_command_inhibit_input); // R3 R4 R18
  assign live = elem_en_reg & {N_ELEM{prot_active}}; // R15 R1

  // Per-element definite-time stage
  genvar g;
  generate
    for (g = 0; g < N_ELEM; g++)
    begin : g_elem
      // Timer restarts whenever the fault drops out
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          timer_reg[g] <= '0;
        else if (!(live[g] && fault_detect[g]))
          timer_reg[g] <= '0; // R7
        else if (timer_reg[g] != delay_reg[g])
          timer_reg[g] <= timer_reg[g] + 1'b1;
      end
      assign alarm_next[g] = live[g] && fault_detect[g]; // R6
      // Trip needs the fault still present once the delay is reached
      assign trip_next[g] = alarm_next[g] && (timer_reg[g] == delay_reg[g]); // R7
      assign order_next[g] = trip_next[g] && !superv_reg[g]
                             && !stage_inh_reg[g] && !cmd_block; // R10 R5 R16
    end
  endgenerate

  // Collective and phase signals
  always_comb
  begin
    gen_alarm_next = |(alarm_next & ~superv_reg); // R8 R5
    gen_trip_next  = |(trip_next & ~superv_reg); // R9 R5
    ph_alarm_next  = '0;
    ph_trip_next   = '0;
    brk_next       = '0;
    for (int e = 0; e < N_ELEM; e++)
    begin
      if (single_ph_reg[e] && !superv_reg[e]) // R11
      begin
        for (int p = 0; p < N_PH; p++)
        begin
          ph_alarm_next[p] = ph_alarm_next[p]
                             || (alarm_next[e] && fault_phase[e*N_PH+p]); // R12
          ph_trip_next[p]  = ph_trip_next[p]
                             || (trip_next[e] && fault_phase[e*N_PH+p]); // R13
        end
      end
      for (int b = 0; b < N_BRK; b++)
      begin
        brk_next[b] = brk_next[b] || (order_next[e] && brk_map_reg[b*N_ELEM+e]); // R14
      end
    end
  end

  // Registered outputs, cleared by reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      elem_alarm           <= '0; // R17
      elem_trip            <= '0;
      breaker_open_order   <= '0;
      general_alarm        <= 1'b0;
      general_trip         <= 1'b0;
      phase_alarm          <= '0;
      phase_trip           <= '0;
      breaker_open_request <= '0;
    end
    else
    begin
      elem_alarm           <= alarm_next;
      elem_trip            <= trip_next;
      breaker_open_order   <= order_next;
      general_alarm        <= gen_alarm_next;
      general_trip         <= gen_trip_next;
      phase_alarm          <= ph_alarm_next;
      phase_trip           <= ph_trip_next;
      breaker_open_request <= brk_next;
    end
  end

  // Rising edges of collective results raise events
  assign event_next[EV_GEN_ALARM]  = gen_alarm_next && !general_alarm;
  assign event_next[EV_GEN_TRIP]   = gen_trip_next && !general_trip;
  assign event_next[EV_OPEN_ORDER] = (|brk_next) && !(|breaker_open_request);

  // Write channel capture, address and data in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end

  // Ready only while the channel slot is free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Setting registers; only byte lane 0 matters for the narrow fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      master_ctrl_reg <= MASTER_CTRL_RST;
      elem_en_reg     <= '0;
      superv_reg      <= '0;
      stage_inh_reg   <= '0;
      single_ph_reg   <= '0;
      brk_map_reg     <= '0;
      irq_mask_reg    <= '0;
      for (int k = 0; k < N_ELEM; k++)
        delay_reg[k] <= '0;
    end
    else if (wr_fire && wstrb_reg[0])
    begin
      if (awaddr_reg == MASTER_CTRL_OFS)
        master_ctrl_reg <= wdata_reg[3:0];
      else if (awaddr_reg == ELEM_EN_OFS)
        elem_en_reg <= wdata_reg[N_ELEM-1:0];
      else if (awaddr_reg == SUPERV_OFS)
        superv_reg <= wdata_reg[N_ELEM-1:0];
      else if (awaddr_reg == STAGE_INH_OFS)
        stage_inh_reg <= wdata_reg[N_ELEM-1:0];
      else if (awaddr_reg == SINGLE_PH_OFS)
        single_ph_reg <= wdata_reg[N_ELEM-1:0];
      else if (awaddr_reg == BRK_MAP_OFS)
        brk_map_reg <= wdata_reg[N_ELEM*N_BRK-1:0];
      else if (awaddr_reg == IRQ_MASK_OFS)
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
      else if (delay_index(awaddr_reg) >= 0)
        delay_reg[delay_index(awaddr_reg)] <= wdata_reg[DLY_W-1:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_reg <= '0;
    else if (wr_fire && wstrb_reg[0] && awaddr_reg == IRQ_STAT_OFS)
      irq_stat_reg <= (irq_stat_reg & ~wdata_reg[IRQ_W-1:0]) | event_next;
    else
      irq_stat_reg <= irq_stat_reg | event_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_reg == MASTER_CTRL_OFS || awaddr_reg == ELEM_EN_OFS
          || awaddr_reg == SUPERV_OFS || awaddr_reg == STAGE_INH_OFS
          || awaddr_reg == SINGLE_PH_OFS || awaddr_reg == BRK_MAP_OFS
          || awaddr_reg == IRQ_MASK_OFS || awaddr_reg == IRQ_STAT_OFS
          || awaddr_reg == STATUS_OFS || delay_index(awaddr_reg) >= 0)
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode
  always_comb
  begin
    rd_data_next = '0;
    rd_ok_next   = 1'b1;
    if (s_axi_araddr == MASTER_CTRL_OFS)
      rd_data_next[3:0] = master_ctrl_reg;
    else if (s_axi_araddr == ELEM_EN_OFS)
      rd_data_next[N_ELEM-1:0] = elem_en_reg;
    else if (s_axi_araddr == SUPERV_OFS)
      rd_data_next[N_ELEM-1:0] = superv_reg;
    else if (s_axi_araddr == STAGE_INH_OFS)
      rd_data_next[N_ELEM-1:0] = stage_inh_reg;
    else if (s_axi_araddr == SINGLE_PH_OFS)
      rd_data_next[N_ELEM-1:0] = single_ph_reg;
    else if (s_axi_araddr == BRK_MAP_OFS)
      rd_data_next[N_ELEM*N_BRK-1:0] = brk_map_reg;
    else if (s_axi_araddr == STATUS_OFS)
    begin
      rd_data_next[ST_GEN_ALARM]  = general_alarm;
      rd_data_next[ST_GEN_TRIP]   = general_trip;
      rd_data_next[ST_PROT_BLOCK] = !prot_active;
      rd_data_next[ST_CMD_BLOCK]  = cmd_block;
    end
    else if (s_axi_araddr == IRQ_STAT_OFS)
      rd_data_next[IRQ_W-1:0] = irq_stat_reg;
    else if (s_axi_araddr == IRQ_MASK_OFS)
      rd_data_next[IRQ_W-1:0] = irq_mask_reg;
    else if (delay_index(s_axi_araddr) >= 0)
      rd_data_next[DLY_W-1:0] = delay_reg[delay_index(s_axi_araddr)];
    else
      rd_ok_next = 1'b0;
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data_next;
        s_axi_rresp  <= rd_ok_next ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : protection_trip_aggregator

// ===== testbench/trip_properties.sv
`timescale 1ns/100ps

module trip_checker
#(
  parameter int N_ELEM = 4,
  parameter int N_PH   = 3,
  parameter int N_BRK  = 2
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [N_ELEM-1:0] fault_detect,
  input wire logic [N_ELEM-1:0] elem_alarm,
  input wire logic [N_ELEM-1:0] elem_trip,
  input wire logic [N_ELEM-1:0] breaker_open_order,
  input wire logic              general_alarm,
  input wire logic              general_trip,
  input wire logic [N_PH-1:0]   phase_alarm,
  input wire logic [N_PH-1:0]   phase_trip,
  input wire logic [N_BRK-1:0]  breaker_open_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // First edge that sees reset released
  sequence s_release;
    $rose(aresetn);
  endsequence

  // Collective, phase and breaker request outputs must come out of reset quiet
  a_reset_clears: assert property (s_release |-> !general_alarm && !general_trip &&
    phase_alarm == '0 && phase_trip == '0 && breaker_open_request == '0)
    else $error("output active after reset");
  // Alarm only one cycle after its criterion
  a_alarm_cause: assert property ((elem_alarm & ~$past(fault_detect)) == '0)
    else $error("alarm without fault");
  a_trip_alarm: assert property ((elem_trip & ~elem_alarm) == '0)
    else $error("trip without alarm");
  a_order_trip: assert property ((breaker_open_order & ~elem_trip) == '0)
    else $error("order without trip");
  a_gen_alarm: assert property (general_alarm |-> |elem_alarm)
    else $error("general alarm without source");
  a_gen_trip: assert property (general_trip |-> |elem_trip)
    else $error("general trip without source");
  a_phase_alarm: assert property (|phase_alarm |-> general_alarm)
    else $error("phase alarm without general alarm");
  a_phase_trip: assert property (|phase_trip |-> general_trip)
    else $error("phase trip without general trip");
  a_request_src: assert property (|breaker_open_request |-> |breaker_open_order)
    else $error("request without order");
endmodule : trip_checker

bind protection_trip_aggregator trip_checker #(.N_ELEM(N_ELEM), .N_PH(N_PH), .N_BRK(N_BRK))
  u_chk (.aclk(aclk), .aresetn(aresetn), .fault_detect(fault_detect),
  .elem_alarm(elem_alarm), .elem_trip(elem_trip), .breaker_open_order(breaker_open_order),
  .general_alarm(general_alarm), .general_trip(general_trip), .phase_alarm(phase_alarm),
  .phase_trip(phase_trip), .breaker_open_request(breaker_open_request));

// ===== testbench/fault_source.sv
`timescale 1ns/100ps

// Measuring side of the elements; changes only after an edge
module fault_source
(
  input  wire logic        aclk,
  input  wire logic [3:0]  want_det,
  input  wire logic [11:0] want_ph,
  output logic      [3:0]  fault_detect = 4'h0,
  output logic      [11:0] fault_phase = 12'h000
);
  // Criterion held as a level, as a real element would
  always_ff @(posedge aclk)
  begin
    fault_detect <= want_det;
    fault_phase  <= want_ph;
  end
endmodule : fault_source

// ===== testbench/protection_trip_aggregator_tb.sv
`timescale 1ns/100ps

module protection_trip_aggregator_tb;
  import prot_pkg::*;
  logic        aclk, aresetn, ext_a, ext_b, ext_i, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, breaker_open_request;
  logic [3:0]  want_det, fault_detect, elem_alarm, elem_trip, breaker_open_order;
  logic [11:0] want_ph, fault_phase;
  logic        general_alarm, general_trip;
  logic [2:0]  phase_alarm, phase_trip;
  logic [3:0]  wstrb;
  int          failures, compares;

  // Free-running protection clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  protection_trip_aggregator u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_detect(fault_detect), .fault_phase(fault_phase), .ext_block_input_a(ext_a),
    .ext_block_input_b(ext_b), .ext_command_inhibit_input(ext_i),
    .elem_alarm(elem_alarm), .elem_trip(elem_trip), .breaker_open_order(breaker_open_order),
    .general_alarm(general_alarm), .general_trip(general_trip), .phase_alarm(phase_alarm),
    .phase_trip(phase_trip), .breaker_open_request(breaker_open_request), .irq(irq));

  fault_source u_src (.aclk(aclk), .want_det(want_det), .want_ph(want_ph),
    .fault_detect(fault_detect), .fault_phase(fault_phase));

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Ready sampled mid-cycle; registered outputs are stable there
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, got;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      got = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end while (!got);
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, got;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
    end while (!got);
    rready <= 1'b0;
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic fault(input logic [3:0] d, input logic [11:0] p);
    @(posedge aclk);
    want_det <= d;
    want_ph <= p;
    settle();
  endtask : fault

  task automatic ext(input logic a, input logic b, input logic i);
    @(posedge aclk);
    ext_a <= a;
    ext_b <= b;
    ext_i <= i;
    settle();
  endtask : ext

  task automatic look(input logic [3:0] ea, et, eo, input logic [1:0] g,
                      input logic [2:0] pa, pt, input logic [1:0] br);
    chk(32'({elem_alarm, elem_trip, breaker_open_order, general_alarm, general_trip,
      phase_alarm, phase_trip, breaker_open_request}), 32'({ea, et, eo, g, pa, pt, br}));
  endtask : look

  task automatic t_reset();
    rd(MASTER_CTRL_OFS, 32'h0, RESP_OKAY);
    rd(STATUS_OFS, 32'h4, RESP_OKAY);
    rd(8'h3C, 32'h0, RESP_SLVERR);
    wr(8'h3C, 32'h1, RESP_SLVERR);
    // Lane 0 strobe low: the write is answered but changes nothing
    @(posedge aclk);
    wstrb <= 4'hE;
    wr(MASTER_CTRL_OFS, 32'hF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(MASTER_CTRL_OFS, 32'h0, RESP_OKAY);
    look(4'h0, 4'h0, 4'h0, 2'h0, 3'h0, 3'h0, 2'h0);
    $display("test reset done");
  endtask : t_reset

  // Elements 0,1 feed breaker 0; 2,3 breaker 1; element 3 not single-phase
  task automatic t_route();
    wr(MASTER_CTRL_OFS, 32'h1, RESP_OKAY);
    wr(ELEM_EN_OFS, 32'hF, RESP_OKAY);
    wr(SINGLE_PH_OFS, 32'h7, RESP_OKAY);
    wr(BRK_MAP_OFS, 32'hC3, RESP_OKAY);
    wr(DELAY_BASE_OFS + 8'h04, 32'h3, RESP_OKAY);
    rd(BRK_MAP_OFS, 32'hC3, RESP_OKAY);
    rd(DELAY_BASE_OFS + 8'h04, 32'h3, RESP_OKAY);
    fault(4'h1, 12'h002);
    look(4'h1, 4'h1, 4'h1, 2'h3, 3'h2, 3'h2, 2'h1);
    fault(4'h8, 12'h200);
    look(4'h8, 4'h8, 4'h8, 2'h3, 3'h0, 3'h0, 2'h2);
    $display("test route done");
  endtask : t_route

  // Element 1 waits three cycles past its alarm
  task automatic t_delay();
    int i;
    @(posedge aclk);
    want_det <= 4'h2;
    want_ph <= 12'h000;
    for (i = 0; i < 20 && elem_alarm[1] !== 1'b1; i++)
      @(negedge aclk);
    chk(32'(elem_alarm[1]), 32'h1);
    for (i = 0; i < 3; i++)
    begin
      chk(32'(elem_trip[1]), 32'h0);
      @(negedge aclk);
    end
    chk(32'(elem_trip[1]), 32'h1);
    $display("test delay done");
  endtask : t_delay

  task automatic t_superv();
    wr(SUPERV_OFS, 32'h1, RESP_OKAY);
    fault(4'h1, 12'h002);
    look(4'h1, 4'h1, 4'h0, 2'h0, 3'h0, 3'h0, 2'h0);
    wr(SUPERV_OFS, 32'h0, RESP_OKAY);
    $display("test superv done");
  endtask : t_superv

  // Element 0 faulted throughout; block sources one by one
  task automatic t_block();
    wr(MASTER_CTRL_OFS, 32'h3, RESP_OKAY);
    ext(1'b1, 1'b0, 1'b0);
    look(4'h0, 4'h0, 4'h0, 2'h0, 3'h0, 3'h0, 2'h0);
    ext(1'b0, 1'b1, 1'b0);
    look(4'h0, 4'h0, 4'h0, 2'h0, 3'h0, 3'h0, 2'h0);
    ext(1'b0, 1'b0, 1'b1);
    look(4'h1, 4'h1, 4'h1, 2'h3, 3'h2, 3'h2, 2'h1);
    wr(MASTER_CTRL_OFS, 32'h9, RESP_OKAY);
    settle();
    look(4'h1, 4'h1, 4'h0, 2'h3, 3'h2, 3'h2, 2'h0);
    ext(1'b0, 1'b0, 1'b0);
    wr(MASTER_CTRL_OFS, 32'h5, RESP_OKAY);
    settle();
    look(4'h1, 4'h1, 4'h0, 2'h3, 3'h2, 3'h2, 2'h0);
    rd(STATUS_OFS, 32'hB, RESP_OKAY);
    wr(MASTER_CTRL_OFS, 32'h1, RESP_OKAY);
    wr(STAGE_INH_OFS, 32'h1, RESP_OKAY);
    fault(4'h5, 12'h102);
    look(4'h5, 4'h5, 4'h4, 2'h3, 3'h6, 3'h6, 2'h2);
    wr(ELEM_EN_OFS, 32'hE, RESP_OKAY);
    settle();
    look(4'h4, 4'h4, 4'h4, 2'h3, 3'h4, 3'h4, 2'h2);
    wr(MASTER_CTRL_OFS, 32'h0, RESP_OKAY);
    settle();
    look(4'h0, 4'h0, 4'h0, 2'h0, 3'h0, 3'h0, 2'h0);
    wr(STAGE_INH_OFS, 32'h0, RESP_OKAY);
    wr(ELEM_EN_OFS, 32'hF, RESP_OKAY);
    fault(4'h0, 12'h000);
    $display("test block done");
  endtask : t_block

  task automatic t_irq();
    wr(MASTER_CTRL_OFS, 32'h1, RESP_OKAY);
    wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
    wr(IRQ_MASK_OFS, 32'h2, RESP_OKAY);
    fault(4'h1, 12'h002);
    chk(32'(irq), 32'h1);
    rd(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
    fault(4'h0, 12'h000);
    wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
    settle();
    chk(32'(irq), 32'h0);
    wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
    fault(4'h1, 12'h002);
    chk(32'(irq), 32'h0);
    rd(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
    $display("test irq done");
  endtask : t_irq

  // Main sequence
  initial
  begin
    failures = 0;
    compares = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ext_a, ext_b, ext_i} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    want_det = 4'h0;
    want_ph = 12'h000;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_route();
    t_delay();
    fault(4'h0, 12'h000);
    t_superv();
    t_block();
    t_irq();
    summarize();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    summarize();
  end
endmodule : protection_trip_aggregator_tb
